// ==== cpr_cmd_decoder.sv ====
// Prefetch, removal lock and short read command decoder with Wishbone slave
// What this block does
// RL1 - Prefetch fills cache, returns no data
// RL2 - Immediate prefetch posts status after validation
// RL3 - Otherwise status waits for prefetch end
// RL4 - Zero prefetch count means through last block
// RL5 - Already cached blocks are skipped
// RL6 - Completed prefetch reports condition met, linked variant
// RL7 - Immediate with room reports condition met
// RL8 - Immediate without room reports good, fills partially
// RL9 - No removal while any holder remains
// RL10 - Prevent bit sets state and records holder
// RL11 - Release needs all allows plus cache sync
// RL12 - Bus device reset clears all prevention
// RL13 - Hard reset clears all prevention
// RL14 - Prevention drives the eject inhibit output
// RL15 - Short read returns latest written data
// RL16 - Short read starts at given block address
// RL17 - Short read zero count means 256
// RL18 - Short read uses fixed internal cache policy
// RL19 - Relative flag in link adds last block
// RL20 - Without relative flag address used directly
// RL21 - Opcodes and fields decoded from fixed positions
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module cpr_cmd_decoder
   import cpr_pkg::*;
#(
   parameter int         NBLK      = 16,
   parameter int         CACHE_CAP = 8,
   parameter int         NINIT     = 8,
   parameter logic [7:0] ST_GOOD   = 8'h00,
   parameter logic [7:0] ST_CMET   = 8'h01,
   parameter logic [7:0] ST_INTER  = 8'h02,
   parameter logic [7:0] ST_ICMET  = 8'h03,
   parameter logic [7:0] ST_CHECK  = 8'h04
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        eject_button_i,
   output logic             eject_o,
   output logic             eject_inhibit_o
);
   localparam int AW = $clog2(NBLK);
   localparam int CW = 17;

   typedef enum logic [2:0] {CPR_IDLE, CPR_DEC, CPR_PF, CPR_RD} cpr_state_e;

   cpr_state_e  state_r;
   logic [7:0]  cdb_r [CPR_CDB_BYTES];
   logic [31:0] mem_r [NBLK];
   logic        cvld_r [NBLK];
   logic [7:0]  used_r;
   logic [AW-1:0] cur_r;
   logic [CW-1:0] rem_r;
   logic        immed_r, link_r, full_r, busy_r;
   logic        stv_r;
   logic [7:0]  code_r;
   logic [31:0] rdata_r, last_r;
   logic        rdv_r;
   logic [AW-1:0] maddr_r;
   logic [2:0]  init_r;
   logic [NINIT-1:0] hold_r;
   logic        prev_r, pend_r;
   logic        ack_r;
   logic [31:0] dat_r;
   logic        ej_r;

   // Bus decode; one wait state, ack registered
   wire acc   = wb_cyc_i & wb_stb_i & ~ack_r;
   wire wr    = acc & wb_we_i;
   wire rd    = acc & ~wb_we_i;
   wire wr_ct = wr & (wb_adr_i == CPR_CTRL_OFS) & wb_sel_i[0];
   wire wr_c1 = wr & (wb_adr_i == CPR_CTRL_OFS) & wb_sel_i[1];
   wire go    = wr_ct & wb_dat_i[CPR_CTRL_GO_BIT];
   wire bdr   = wr_c1 & wb_dat_i[CPR_CTRL_BDR_BIT];
   wire sync  = wr_c1 & wb_dat_i[CPR_CTRL_SYNC_BIT];
   wire rd_st = rd & (wb_adr_i == CPR_STAT_OFS);
   wire pop   = rd & (wb_adr_i == CPR_RDATA_OFS) & rdv_r;

   // RL21 field decode
   wire [7:0]  opc     = cdb_r[0];
   wire        is_pf   = opc == CPR_OP_PREFETCH;
   wire        is_lk   = opc == CPR_OP_LOCK;
   wire        is_rd   = opc == CPR_OP_READ6;
   wire        pf_imm  = cdb_r[1][CPR_PF_IMMED_BIT];
   wire        pf_rel  = cdb_r[1][CPR_PF_REL_BIT];
   wire [31:0] pf_lba  = {cdb_r[2], cdb_r[3], cdb_r[4], cdb_r[5]};
   wire [15:0] pf_len  = {cdb_r[7], cdb_r[8]};
   wire        pf_link = cdb_r[9][CPR_LINK_BIT];
   wire        lk_prev = cdb_r[4][CPR_PREVENT_BIT];
   wire        lk_link = cdb_r[5][CPR_LINK_BIT];
   wire [20:0] rd_lba  = {cdb_r[1][4:0], cdb_r[2], cdb_r[3]};
   wire [7:0]  rd_len  = cdb_r[4];
   wire        rd_link = cdb_r[5][CPR_LINK_BIT];

   // RL19 relative start only inside a linked group
   wire [31:0] pf_abs  = (pf_rel & pf_link) ? last_r + pf_lba : pf_lba;
   // RL20 direct start block
   wire [AW-1:0] pf_st = pf_abs[AW-1:0];
   // RL4 zero count runs to the last block
   wire [CW-1:0] pf_cnt = (pf_len == 16'h0000) ?
                          CW'(NBLK) - CW'(pf_st) : CW'(pf_len);
   wire [7:0]    free   = 8'(CACHE_CAP) - used_r;
   wire          room   = pf_cnt <= CW'(free);
   // RL17 zero count is 256 blocks
   wire [8:0]    rd_cnt = (rd_len == 8'h00) ? CPR_RD_ZERO_LEN : {1'b0, rd_len};
   wire          bad_rel = pf_rel & ~pf_link;
   wire          lk_cmd  = (state_r == CPR_DEC) & is_lk;
   wire [NINIT-1:0] hold_nxt = lk_cmd ?
      ((hold_r & ~(NINIT'(1) << init_r)) | (NINIT'(lk_prev) << init_r)) :
      hold_r;

   wire pf_step = (state_r == CPR_PF) & (rem_r != '0);
   wire pf_hit  = cvld_r[cur_r];
   wire pf_fill = pf_step & ~pf_hit & (used_r < 8'(CACHE_CAP));
   wire rd_step = (state_r == CPR_RD) & (rem_r != '0) & ~rdv_r;

   function automatic logic [7:0] linked(input logic lk, input logic [7:0] a,
                                         input logic [7:0] b);
      linked = lk ? b : a;
   endfunction

   // Wishbone slave and descriptor capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r   <= 1'b0;
         dat_r   <= CPR_WORD_RST;
         maddr_r <= '0;
         for (int i = 0; i < CPR_CDB_BYTES; i++) cdb_r[i] <= CPR_BYTE_RST;
      end else begin
         ack_r <= acc;
         dat_r <= rd ? rdmux(wb_adr_i) : CPR_WORD_RST;
         for (int i = 0; i < CPR_CDB_BYTES; i++) begin
            if (wr & (wb_adr_i == 8'(4 * (i / 4))) & wb_sel_i[i % 4] &
                (state_r == CPR_IDLE))
               cdb_r[i] <= wb_dat_i[8 * (i % 4) +: 8];
         end
         if (wr & (wb_adr_i == CPR_MADDR_OFS))
            maddr_r <= wb_dat_i[AW-1:0];
      end
   end

   function automatic logic [31:0] rdmux(input logic [7:0] a);
      rdmux = CPR_WORD_RST;
      case (a)
         CPR_CDB0_OFS:  rdmux = {cdb_r[3], cdb_r[2], cdb_r[1], cdb_r[0]};
         CPR_CDB1_OFS:  rdmux = {cdb_r[7], cdb_r[6], cdb_r[5], cdb_r[4]};
         CPR_CDB2_OFS:  rdmux = {cdb_r[11], cdb_r[10], cdb_r[9], cdb_r[8]};
         CPR_STAT_OFS:  rdmux = {used_r, 8'(hold_r), 3'b000, pend_r, rdv_r,
                                 prev_r, busy_r, stv_r, code_r};
         CPR_RDATA_OFS: rdmux = rdata_r;
         CPR_MADDR_OFS: rdmux = 32'(maddr_r);
         CPR_MDATA_OFS: rdmux = mem_r[maddr_r];
         CPR_LASTB_OFS: rdmux = last_r;
         default:       rdmux = CPR_WORD_RST;
      endcase
   endfunction

   // RL15 medium store, latest write always wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NBLK; i++) mem_r[i] <= CPR_WORD_RST;
      end else if (wr & (wb_adr_i == CPR_MDATA_OFS)) begin
         mem_r[maddr_r] <= wb_dat_i;
      end
   end

   // Command sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= CPR_IDLE;
         cur_r   <= '0;
         rem_r   <= '0;
         immed_r <= 1'b0;
         link_r  <= 1'b0;
         full_r  <= 1'b0;
         busy_r  <= 1'b0;
         init_r  <= '0;
         last_r  <= CPR_WORD_RST;
      end else begin
         case (state_r)
            CPR_IDLE: begin
               if (go) begin
                  state_r <= CPR_DEC;
                  busy_r  <= 1'b1;
                  init_r  <= wb_dat_i[CPR_CTRL_INIT_LSB +: 3];
               end
            end
            CPR_DEC: begin
               full_r <= 1'b0;
               if (is_pf & ~bad_rel) begin
                  state_r <= CPR_PF;
                  cur_r   <= pf_st;
                  rem_r   <= pf_cnt;
                  immed_r <= pf_imm;
                  link_r  <= pf_link;
               end else if (is_rd) begin
                  // RL16 read starts at the given block
                  state_r <= CPR_RD;
                  cur_r   <= rd_lba[AW-1:0];
                  rem_r   <= CW'(rd_cnt);
                  link_r  <= rd_link;
               end else begin
                  state_r <= CPR_IDLE;
                  busy_r  <= 1'b0;
               end
            end
            CPR_PF: begin
               // RL1 blocks go to cache only
               if (rem_r == '0) begin
                  state_r <= CPR_IDLE;
                  busy_r  <= 1'b0;
               end else begin
                  // RL8 partial fill stops when cache is full
                  if (~pf_hit & ~pf_fill) full_r <= 1'b1;
                  cur_r  <= cur_r + 1'b1;
                  rem_r  <= rem_r - 1'b1;
                  last_r <= 32'(cur_r);
               end
            end
            CPR_RD: begin
               if ((rem_r == '0) & ~rdv_r) begin
                  state_r <= CPR_IDLE;
                  busy_r  <= 1'b0;
               end else if (rd_step) begin
                  cur_r  <= cur_r + 1'b1;
                  rem_r  <= rem_r - 1'b1;
                  last_r <= 32'(cur_r);
               end
            end
            default: begin
               state_r <= CPR_IDLE;
               busy_r  <= 1'b0;
            end
         endcase
      end
   end

   // RL5 cache fill skips resident blocks; RL18 fixed policy, reads bypass
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         used_r <= CPR_BYTE_RST;
         for (int i = 0; i < NBLK; i++) cvld_r[i] <= 1'b0;
      end else if (pf_fill) begin
         cvld_r[cur_r] <= 1'b1;
         used_r        <= used_r + 8'h01;
      end
   end

   // Read data window, one block at a time; a read of it pops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdv_r   <= 1'b0;
         rdata_r <= CPR_WORD_RST;
      end else if (rd_step) begin
         rdata_r <= mem_r[cur_r];
         rdv_r   <= 1'b1;
      end else if (pop) begin
         rdv_r <= 1'b0;
      end
   end

   // Status posting; a new status wins over a status read clearing it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stv_r  <= 1'b0;
         code_r <= CPR_BYTE_RST;
      end else if (state_r == CPR_DEC) begin
         stv_r <= is_lk | (is_pf & (pf_imm | bad_rel)) | ~(is_pf | is_rd);
         // RL2 immediate status right after validation
         // RL7 enough room gives condition met
         if (is_pf & bad_rel)
            code_r <= ST_CHECK;
         else if (is_pf)
            code_r <= room ? linked(pf_link, ST_CMET, ST_ICMET)
                           : linked(pf_link, ST_GOOD, ST_INTER);
         else if (is_lk)
            code_r <= linked(lk_link, ST_GOOD, ST_INTER);
         else
            code_r <= ST_CHECK;
      end else if ((state_r == CPR_PF) & (rem_r == '0) & ~immed_r) begin
         // RL3 status only after the fill
         // RL6 full success gives condition met
         stv_r  <= 1'b1;
         code_r <= full_r ? ST_CHECK : linked(link_r, ST_CMET, ST_ICMET);
      end else if ((state_r == CPR_RD) & (rem_r == '0) & ~rdv_r) begin
         stv_r  <= 1'b1;
         code_r <= linked(link_r, ST_GOOD, ST_INTER);
      end else if (rd_st) begin
         stv_r <= 1'b0;
      end
   end

   // RL12 bus device reset clears holders and prevention; RL13 hard reset too
   always_ff @(posedge clk_i) begin
      if (rst_i | bdr) begin
         hold_r <= '0;
         prev_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         hold_r <= hold_nxt;
         // RL10 prevent bit records holder
         if (lk_cmd & lk_prev) begin
            prev_r <= 1'b1;
            pend_r <= 1'b0;
         end else if (prev_r & (hold_nxt == '0) & pend_r & sync) begin
            // RL11 all allowed and cache synced
            prev_r <= 1'b0;
            pend_r <= 1'b0;
         end else if (prev_r & (hold_nxt == '0)) begin
            pend_r <= 1'b1;
         end
      end
   end

   // RL9 eject refused while prevented; RL14 inhibit output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ej_r            <= 1'b0;
         eject_inhibit_o <= 1'b0;
      end else begin
         ej_r            <= eject_button_i & ~prev_r;
         eject_inhibit_o <= prev_r;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign eject_o  = ej_r;

   // Checks
   bus_ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> ~wb_ack_o)
      else $error("ack held two cycles");
   inhibit_follows_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
      prev_r |=> eject_inhibit_o)
      else $error("inhibit not driven by prevention");
   eject_blocked_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
      prev_r |=> ~eject_o)
      else $error("eject while prevented");
   bdr_clears_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
      bdr |=> ~prev_r && hold_r == '0)
      else $error("bus device reset left prevention");
   prevent_sets_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
      lk_cmd && lk_prev && !bdr |=> prev_r && hold_r[$past(init_r)])
      else $error("prevent not recorded");
   release_needs_sync_a: assert property (@(posedge clk_i) // RL11
      disable iff (rst_i)
      $fell(prev_r) |-> $past(sync) || $past(bdr))
      else $error("prevention released without sync");
   rd_zero_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
      state_r == CPR_DEC && is_rd && rd_len == 8'h00 |=> rem_r == CW'(256))
      else $error("zero read length not 256");
   immed_status_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
      state_r == CPR_DEC && is_pf && pf_imm |=> stv_r && state_r == CPR_PF)
      else $error("immediate status missing");
   defer_status_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
      state_r == CPR_PF && !immed_r && rem_r != '0 |=> !$rose(stv_r))
      else $error("status before prefetch end");
   no_refill_a: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
      pf_step && pf_hit |=> used_r == $past(used_r))
      else $error("resident block fetched again");
endmodule
`default_nettype wire

// ==== cpr_initiator.sv ====
// Initiator model: classic Wishbone master that feeds the decoder
`timescale 1ns/1ns
`default_nettype none
module cpr_initiator (
   input  wire logic        clk_i,
   output logic             wb_cyc_o,
   output logic             wb_stb_o,
   output logic             wb_we_o,
   output logic [7:0]       wb_adr_o,
   output logic [3:0]       wb_sel_o,
   output logic [31:0]      wb_dat_o,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_i
);
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o  = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'hf;
      wb_dat_o = 32'h0;
   end

   // no cache hints: short reads go out bare, the target picks policy
   // Signals move only after a rising edge; held until ack is sampled
   task automatic xfer(input logic we, input logic [7:0] adr,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= we;
      wb_adr_o <= adr;
      wb_dat_o <= wd;
      @(posedge clk_i);
      while (wb_ack_i !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o  <= 1'b0;
      // Released lines must not look like stale valid values
      wb_adr_o <= ~adr;
      wb_dat_o <= ~wd;
   endtask
endmodule
`default_nettype wire

// ==== cpr_pkg.sv ====
// Constants shared by the command decoder: offsets, fields and opcodes
package cpr_pkg;
   // Register byte offsets
   localparam logic [7:0] CPR_CDB0_OFS   = 8'h00;
   localparam logic [7:0] CPR_CDB1_OFS   = 8'h04;
   localparam logic [7:0] CPR_CDB2_OFS   = 8'h08;
   localparam logic [7:0] CPR_CTRL_OFS   = 8'h0c;
   localparam logic [7:0] CPR_STAT_OFS   = 8'h10;
   localparam logic [7:0] CPR_RDATA_OFS  = 8'h14;
   localparam logic [7:0] CPR_MADDR_OFS  = 8'h18;
   localparam logic [7:0] CPR_MDATA_OFS  = 8'h1c;
   localparam logic [7:0] CPR_LASTB_OFS  = 8'h20;
   // Control register fields
   localparam int CPR_CTRL_GO_BIT   = 0;
   localparam int CPR_CTRL_INIT_LSB = 4;
   localparam int CPR_CTRL_BDR_BIT  = 8;
   localparam int CPR_CTRL_SYNC_BIT = 9;
   // Status register fields
   localparam int CPR_ST_VLD_BIT   = 8;
   localparam int CPR_ST_BUSY_BIT  = 9;
   localparam int CPR_ST_PREV_BIT  = 10;
   localparam int CPR_ST_RDV_BIT   = 11;
   localparam int CPR_ST_PEND_BIT  = 12;
   localparam int CPR_ST_HOLD_LSB  = 16;
   localparam int CPR_ST_USED_LSB  = 24;
   // Operation codes in descriptor byte zero
   localparam logic [7:0] CPR_OP_PREFETCH = 8'h34;
   localparam logic [7:0] CPR_OP_LOCK     = 8'h1e;
   localparam logic [7:0] CPR_OP_READ6    = 8'h08;
   // Descriptor bit positions
   localparam int CPR_PF_IMMED_BIT = 1;
   localparam int CPR_PF_REL_BIT   = 0;
   localparam int CPR_LINK_BIT     = 0;
   localparam int CPR_PREVENT_BIT  = 0;
   localparam int CPR_CDB_BYTES    = 12;
   // Zero transfer length of the short read means this many blocks
   localparam logic [8:0] CPR_RD_ZERO_LEN = 9'h100;
   // Reset values
   localparam logic [31:0] CPR_WORD_RST = 32'h0000_0000;
   localparam logic [7:0]  CPR_BYTE_RST = 8'h00;
endpackage

// ==== tb.sv ====
// Self-checking bench for the command decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
   import cpr_pkg::*;
   localparam logic [7:0]  GOOD  = 8'h00;
   localparam logic [7:0]  CMET  = 8'h01;
   localparam logic [7:0]  INTER = 8'h02;
   localparam logic [7:0]  ICMET = 8'h03;
   localparam logic [7:0]  CHK   = 8'h04;
   localparam logic [31:0] V3    = 32'hc0de_0003;
   localparam logic [31:0] V4    = 32'h5a5a_0004;
   logic        clk_i;
   logic        rst_i;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic        btn;
   logic        eject;
   logic        inhib;
   logic [31:0] lastb;
   int          fails = 0;
   int          cmp_count = 0;
   int          cycles = 0;

   cpr_cmd_decoder #(.ST_GOOD(GOOD), .ST_CMET(CMET), .ST_INTER(INTER),
                     .ST_ICMET(ICMET), .ST_CHECK(CHK)) cpr_cmd_decoder_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .eject_button_i(btn),
      .eject_o(eject), .eject_inhibit_o(inhib));

   cpr_initiator cpr_initiator_inst (
      .clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
      .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
      .wb_dat_i(rdat), .wb_ack_i(ack));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Whole run needs a few thousand cycles; this only cuts a hang
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails = fails + 1;
         report_and_stop();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      cpr_initiator_inst.xfer(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      cpr_initiator_inst.xfer(1'b0, a, 32'h0, d);
   endtask

   // Bounded poll of one status bit
   task automatic poll(input int b, input logic v, output logic [31:0] s);
      int n;
      n = 0;
      rd(CPR_STAT_OFS, s);
      while (s[b] !== v && n < 60) begin
         rd(CPR_STAT_OFS, s);
         n++;
      end
      check({31'h0, s[b]}, {31'h0, v});
   endtask

   task automatic cmd(input logic [31:0] w0, w1, w2, input logic [2:0] id);
      wr(CPR_CDB0_OFS, w0);
      wr(CPR_CDB1_OFS, w1);
      wr(CPR_CDB2_OFS, w2);
      wr(CPR_CTRL_OFS, {25'h0, id, 4'h1});
   endtask

   task automatic fin(input logic [7:0] code);
      logic [31:0] s;
      poll(CPR_ST_VLD_BIT, 1'b1, s);
      check({24'h0, s[7:0]}, {24'h0, code});
      poll(CPR_ST_BUSY_BIT, 1'b0, s);
   endtask

   // Medium image as written by the bench; addresses wrap at 16
   function automatic logic [31:0] med(input int b);
      return (b == 3) ? V3 : ((b == 4) ? V4 : 32'h0);
   endfunction

   task automatic rd6(input logic [7:0] a, n, input int cnt);
      logic [31:0] s;
      logic [31:0] d;
      cmd({a, 16'h0, CPR_OP_READ6}, {24'h0, n}, 32'h0, 3'h0);
      for (int i = 0; i < cnt; i++) begin
         poll(CPR_ST_RDV_BIT, 1'b1, s);
         rd(CPR_RDATA_OFS, d);
         check(d, med((int'(a) + i) % 16));
      end
      fin(GOOD);
   endtask

   task automatic pf(input logic im, lk, input logic [7:0] a,
                     input logic [15:0] n, input logic [7:0] code, cnt);
      logic [31:0] s;
      cmd({22'h0, im, 1'b0, CPR_OP_PREFETCH}, {n[15:8], 8'h0, a, 8'h0},
          {23'h0, lk, n[7:0]}, 3'h0);
      fin(code);
      rd(CPR_STAT_OFS, s);
      // Cached count, and no read data offered once the command is done
      check({23'h0, s[31:24], s[CPR_ST_RDV_BIT]}, {23'h0, cnt, 1'b0});
   endtask

   // Expected {holder mask, release pending, prevented}
   task automatic st(input logic [9:0] e);
      logic [31:0] s;
      rd(CPR_STAT_OFS, s);
      check({22'h0, s[23:16], s[12], s[10]}, {22'h0, e});
      check({31'h0, inhib}, {31'h0, e[0]});
   endtask

   task automatic lck(input logic [2:0] id, input logic p,
                      input logic [9:0] e);
      cmd({24'h0, CPR_OP_LOCK}, {31'h0, p}, 32'h0, id);
      fin(GOOD);
      st(e);
   endtask

   task automatic ej(input logic e);
      btn <= 1'b1;
      repeat (3) @(posedge clk_i);
      check({31'h0, eject}, {31'h0, e});
      btn <= 1'b0;
      @(posedge clk_i);
   endtask

   initial begin
      rst_i = 1'b1;
      btn   = 1'b0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wr(CPR_MADDR_OFS, 32'h3);
      wr(CPR_MDATA_OFS, V3);
      wr(CPR_MADDR_OFS, 32'h4);
      wr(CPR_MDATA_OFS, V4);
      rd6(8'h03, 8'h02, 2);
      rd6(8'h03, 8'h00, 256);
      $display("test short read done");
      pf(1'b0, 1'b0, 8'd14, 16'd0, CMET, 8'd2);
      pf(1'b0, 1'b1, 8'd14, 16'd2, ICMET, 8'd2);
      pf(1'b1, 1'b0, 8'd0, 16'd3, CMET, 8'd5);
      pf(1'b1, 1'b1, 8'd8, 16'd8, INTER, 8'd8);
      pf(1'b1, 1'b0, 8'd0, 16'd1, GOOD, 8'd8);
      // Linked relative start: last block 0 plus displacement 5
      cmd(32'h0000_0334, 32'h0000_0500, 32'h0000_0101, 3'h0);
      fin(INTER);
      rd(CPR_LASTB_OFS, lastb);
      check(lastb, 32'h0000_0005);
      // Relative flag outside a linked group is refused
      cmd(32'h0000_0134, 32'h0000_0500, 32'h0000_0001, 3'h0);
      fin(CHK);
      $display("test prefetch done");
      lck(3'd1, 1'b1, {8'h02, 2'b01});
      ej(1'b0);
      lck(3'd2, 1'b1, {8'h06, 2'b01});
      lck(3'd1, 1'b0, {8'h04, 2'b01});
      lck(3'd2, 1'b0, {8'h00, 2'b11});
      ej(1'b0);
      wr(CPR_CTRL_OFS, 32'h200);
      st(10'h000);
      ej(1'b1);
      lck(3'd3, 1'b1, {8'h08, 2'b01});
      wr(CPR_CTRL_OFS, 32'h100);
      st(10'h000);
      lck(3'd4, 1'b1, {8'h10, 2'b01});
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      st(10'h000);
      $display("test removal lock done");
      report_and_stop();
   end
endmodule
`default_nettype wire
